/* File: hdl/adc_pkg.sv */
// constants shared by the converter control block
package adc_pkg;
    // register word indices; byte address is four times the index
    localparam logic [9:0] IDX_CTRL0  = 10'h01f;  // conv_control_zero
    localparam logic [9:0] IDX_CTRL1  = 10'h09f;  // conv_control_one
    localparam logic [9:0] IDX_RES_LO = 10'h0a0;  // result_low_byte
    localparam logic [9:0] IDX_RES_HI = 10'h0a1;  // result_high_byte
    localparam logic [9:0] IDX_STATUS = 10'h0a2;  // conversion_done_flag
    // reset values
    localparam logic [7:0] CTRL0_RST  = 8'h00;
    localparam logic [7:0] CTRL1_RST  = 8'h00;
    // field positions in conv_control_zero
    localparam int CS_HI   = 7;   // conv_clock_select msb
    localparam int CS_LO   = 6;
    localparam int GO_BIT  = 2;   // conversion run bit
    localparam int PWR_BIT = 0;   // converter_power_on
    // field positions in conv_control_one
    localparam int JUST_BIT = 7;  // result_justify
    localparam int REF_HI   = 6;  // reference_select msb
    localparam int REF_LO   = 4;
    localparam int PCFG_HI  = 3;  // pin_analog_config msb
    // clock select codes
    localparam logic [1:0] CS_DIV2 = 2'h0;
    localparam logic [1:0] CS_DIV8 = 2'h1;
    localparam logic [1:0] CS_DIV32 = 2'h2;
    localparam logic [1:0] CS_RC   = 2'h3;
    // system clocks per conversion clock period
    localparam logic [5:0] DIV2_CYC  = 6'h02;
    localparam logic [5:0] DIV8_CYC  = 6'h08;
    localparam logic [5:0] DIV32_CYC = 6'h20;
    // conversion clock periods of one conversion
    localparam logic [3:0] TAD_SETTLE = 4'h1;  // settling period
    localparam logic [3:0] TAD_LAST   = 4'hd;  // last bit period
    // channel codes
    localparam logic [3:0] CH_MAX     = 4'h9;
    localparam logic [3:0] PCFG_ALL_A = 4'h5;  // last all-analog code
    localparam logic [11:0] RES_ONES  = 12'hfff;
    // reference sources
    localparam logic [1:0] REF_SUPPLY = 2'h0;
    localparam logic [1:0] REF_EXT    = 2'h1;
    localparam logic [1:0] REF_INT_H  = 2'h2;
    localparam logic [1:0] REF_INT_L  = 2'h3;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_DONE = 3'b100
    } adc_state_e;
endpackage

/* File: hdl/adc_control.sv */
// converter control: registers, conversion clock, successive approximation sequencing
// Summary of operation
// - ten inputs, one sample-hold, 12-bit result
// - sleep conversion only with internal RC clock
// - reset clears control registers and flag and aborts conversion
// - completion loads result, clears run, sets flag
// - clock select: div2, div8, div32, RC
// - channel field picks 0-9, rest reserved
// - run bit starts, reads busy, self clears
// - power bit enables or shuts down converter
// - justify bit: one right, zero left
// - reference field selects high and low references
// - pin config turns pins digital from nine down
// - unimplemented channel gives all-ones result
// - power-on reset leaves result pair untouched
// - output-driven analog pin converts driven level
// - conversion runs whatever the pin direction and digital mode
// - analog pins read zero on A/E, one on B
// - thirteen periods: one settle, twelve bits
// - flag at 14th rise, run cleared at fall
// - abort by software still writes partial result
// - power and run together: run cleared
`timescale 1ns/1ps
`default_nettype none
module adc_control
    import adc_pkg::*;
#(
    parameter int         NUM_CH     = 10,       // analog inputs
    parameter logic [9:0] PORT_B_MAP = 10'h300,  // inputs that sit on port B
    parameter bit         SMALL_PKG  = 1'b0      // channels 4 to 7 absent
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // system state and internal rc oscillator
    input  wire logic              sleep_mode,
    input  wire logic              rc_clock_pin,
    // analog core
    input  wire logic              comp_in_pin,
    output logic                   converter_power_on,
    output logic                   sample_hold,
    output logic [11:0]            dac_code,
    output logic [3:0]             channel_select,
    output logic                   sample_driven_level,
    output logic [1:0]             ref_high_src,
    output logic [1:0]             ref_low_src,
    // port pins
    input  wire logic [NUM_CH-1:0] pin_direction,
    input  wire logic [NUM_CH-1:0] pin_level,
    output logic [NUM_CH-1:0]      pin_analog,
    output logic [NUM_CH-1:0]      pin_read_value
);
    import adc_pkg::*;

    // register state
    logic [7:0]  ctrl0_reg;        // conv_control_zero without run bit
    logic [7:0]  ctrl1_reg;        // conv_control_one
    logic        run_reg;          // conversion run bit
    logic        done_reg;         // conversion_done_flag
    logic [11:0] result_reg;       // raw result, never reset
    logic [11:0] sar_reg;          // approximation register
    logic [3:0]  tad_reg;          // conversion clock periods seen
    logic [5:0]  div_reg;          // system clock divider
    adc_state_e  state_reg;        // sequencer state
    // synchronisers
    logic [1:0]  rc_sync;          // rc oscillator
    logic        rc_last;          // rc level one cycle back
    logic [NUM_CH-1:0] lvl_s1;     // pin levels, first stage
    logic [NUM_CH-1:0] lvl_s2;     // pin levels, second stage
    // bus strobes
    logic        wr_go;            // write accepted this cycle
    logic [9:0]  wr_idx;           // word index written
    logic [9:0]  rd_idx;           // word index read
    logic        wr_ctrl0;         // conv_control_zero byte written
    // conversion clock
    logic [5:0]  div_cyc;          // selected divide ratio
    logic        tad_rise;         // start of a conversion clock period
    logic        tad_fall;         // middle of a conversion clock period
    logic        clk_ok;           // conversion clock may run
    // decode
    logic [3:0]  chan;             // selected channel
    logic        chan_bad;         // reserved or absent channel
    logic [4:0]  dig_cnt;          // pins turned digital
    logic [15:0] res_pair;         // justified result pair
    logic        sw_abort;         // software cleared the run bit

    assign wr_go    = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign wr_idx   = s_axi_awaddr[11:2];
    assign rd_idx   = s_axi_araddr[11:2];
    assign wr_ctrl0 = wr_go && s_axi_wstrb[0] && (wr_idx == IDX_CTRL0);
    assign sw_abort = wr_ctrl0 && !s_axi_wdata[GO_BIT];

    // both write channels are taken together, answer follows next edge
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = !s_axi_rvalid;

    // write response channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            // unmapped words answer slave error
            s_axi_bresp  <= (wr_idx == IDX_CTRL0 || wr_idx == IDX_CTRL1 ||
                             wr_idx == IDX_RES_LO || wr_idx == IDX_RES_HI ||
                             wr_idx == IDX_STATUS) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // justify the stored result
    always_comb begin
        if (ctrl1_reg[JUST_BIT]) begin
            res_pair = {4'h0, result_reg};
        end else begin
            res_pair = {result_reg, 4'h0};
        end
    end

    // read data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (rd_idx)
                IDX_CTRL0:  begin
                    // run bit reads one while converting
                    s_axi_rdata <= {24'h0, ctrl0_reg[7:3], run_reg,
                                    ctrl0_reg[1:0]};
                end
                IDX_CTRL1:  s_axi_rdata <= {24'h0, ctrl1_reg};
                IDX_RES_LO: s_axi_rdata <= {24'h0, res_pair[7:0]};
                IDX_RES_HI: s_axi_rdata <= {24'h0, res_pair[15:8]};
                IDX_STATUS: s_axi_rdata <= {31'h0, done_reg};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // control registers; run bit kept apart in the sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl0_reg <= CTRL0_RST;
            ctrl1_reg <= CTRL1_RST;
        end else if (wr_go && s_axi_wstrb[0]) begin
            if (wr_idx == IDX_CTRL0) begin
                ctrl0_reg <= s_axi_wdata[7:0];
            end
            if (wr_idx == IDX_CTRL1) begin
                ctrl1_reg <= s_axi_wdata[7:0];
            end
        end
    end

    // completion flag: hardware set wins over write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_reg <= 1'b0;
        end else if (state_reg == ST_CONV && tad_rise && tad_reg == TAD_LAST) begin
            done_reg <= 1'b1;
        end else if (wr_go && s_axi_wstrb[0] && wr_idx == IDX_STATUS &&
                     s_axi_wdata[0]) begin
            done_reg <= 1'b0;
        end
    end

    // synchronisers for rc clock and pin levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rc_sync   <= 2'h0;
            rc_last   <= 1'b0;
            lvl_s1    <= '0;
            lvl_s2    <= '0;
        end else begin
            rc_sync   <= {rc_sync[0], rc_clock_pin};
            rc_last   <= rc_sync[1];
            lvl_s1    <= pin_level;
            lvl_s2    <= lvl_s1;
        end
    end

    // divide ratio from the clock select field
    always_comb begin
        case (ctrl0_reg[CS_HI:CS_LO])
            CS_DIV2:  div_cyc = DIV2_CYC;
            CS_DIV8:  div_cyc = DIV8_CYC;
            CS_DIV32: div_cyc = DIV32_CYC;
            default:  div_cyc = DIV2_CYC;
        endcase
    end

    // system clock stops in sleep, only rc keeps converting
    assign clk_ok = !sleep_mode || ctrl0_reg[CS_HI:CS_LO] == CS_RC;

    // divider runs only during a conversion
    always_ff @(posedge aclk) begin
        if (!aresetn || state_reg == ST_IDLE) begin
            div_reg <= 6'h0;
        end else if (clk_ok) begin
            div_reg <= (div_reg == div_cyc - 6'h1) ? 6'h0 : div_reg + 6'h1;
        end
    end

    // conversion clock edges as one-cycle enables
    always_comb begin
        if (!clk_ok || state_reg == ST_IDLE) begin
            tad_rise = 1'b0;
            tad_fall = 1'b0;
        end else if (ctrl0_reg[CS_HI:CS_LO] == CS_RC) begin
            tad_rise = rc_sync[1] && !rc_last;
            tad_fall = !rc_sync[1] && rc_last;
        end else begin
            tad_rise = div_reg == 6'h0;
            tad_fall = div_reg == (div_cyc >> 1);
        end
    end

    // sequencer: settle one period, twelve bit periods, then finish
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            run_reg   <= 1'b0;
            tad_reg   <= 4'h0;
            sar_reg   <= 12'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    tad_reg <= 4'h0;
                    // start needs power already on; joint write clears run
                    if (wr_ctrl0 && s_axi_wdata[GO_BIT] &&
                        ctrl0_reg[PWR_BIT] && s_axi_wdata[PWR_BIT]) begin
                        run_reg   <= 1'b1;
                        state_reg <= ST_CONV;
                        sar_reg   <= 12'h0;
                    end else begin
                        run_reg <= 1'b0;
                    end
                end
                ST_CONV: begin
                    if (sw_abort || !ctrl0_reg[PWR_BIT]) begin
                        run_reg   <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else if (tad_rise) begin
                        tad_reg <= tad_reg + 4'h1;
                        if (tad_reg == TAD_LAST) begin
                            state_reg <= ST_DONE;
                        end else if (tad_reg >= TAD_SETTLE) begin
                            // try the next bit, msb first
                            sar_reg[4'd12 - tad_reg] <= 1'b1;
                        end
                    end else if (tad_fall && tad_reg > TAD_SETTLE) begin
                        // comparator follows dac_code on this clock: no sync
                        if (!comp_in_pin) begin
                            sar_reg[4'd13 - tad_reg] <= 1'b0;
                        end
                    end
                end
                ST_DONE: begin
                    // run clears at the falling edge of the last period
                    if (tad_fall || sw_abort || !ctrl0_reg[PWR_BIT]) begin
                        run_reg   <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    run_reg   <= 1'b0;
                end
            endcase
        end
    end

    // result pair: loaded at completion or software abort, untouched by reset
    always_ff @(posedge aclk) begin
        if (state_reg == ST_CONV && tad_rise && tad_reg == TAD_LAST && aresetn) begin
            result_reg <= chan_bad ? RES_ONES : sar_reg;
        end else if (state_reg == ST_CONV && sw_abort && aresetn) begin
            result_reg <= chan_bad ? RES_ONES : sar_reg;
        end
    end

    // channel decode from bits 5:3 and 1
    assign chan     = {ctrl0_reg[5:3], ctrl0_reg[1]};
    assign chan_bad = chan > CH_MAX ||
                      (SMALL_PKG && chan[3:2] == 2'h1);

    // pins turned digital, counting down from input nine
    assign dig_cnt = (ctrl1_reg[PCFG_HI:0] > PCFG_ALL_A) ?
                     {1'b0, ctrl1_reg[PCFG_HI:0] - PCFG_ALL_A} : 5'h0;

    // reference source decode
    always_comb begin
        case (ctrl1_reg[REF_HI:REF_LO])
            3'h0: begin ref_high_src = REF_SUPPLY; ref_low_src = REF_SUPPLY; end
            3'h1: begin ref_high_src = REF_EXT;    ref_low_src = REF_EXT;    end
            3'h2: begin ref_high_src = REF_INT_H;  ref_low_src = REF_INT_L;  end
            3'h3: begin ref_high_src = REF_EXT;    ref_low_src = REF_SUPPLY; end
            3'h4: begin ref_high_src = REF_INT_H;  ref_low_src = REF_SUPPLY; end
            3'h5: begin ref_high_src = REF_SUPPLY; ref_low_src = REF_EXT;    end
            3'h6: begin ref_high_src = REF_SUPPLY; ref_low_src = REF_INT_L;  end
            default: begin
                ref_high_src = REF_INT_L;
                ref_low_src  = REF_SUPPLY;
            end
        endcase
    end

    // analog core drives
    assign converter_power_on = ctrl0_reg[PWR_BIT];
    assign sample_hold        = state_reg == ST_IDLE;
    assign dac_code           = sar_reg;
    assign channel_select     = chan;
    // output pin: driven level is what gets sampled; direction never blocks
    assign sample_driven_level = !chan_bad &&
                                 !pin_direction[chan];

    // analog mask and port read value
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_pin
            assign pin_analog[gi] = (NUM_CH - 1 - gi) >= int'(dig_cnt);
            assign pin_read_value[gi] = pin_analog[gi] ? PORT_B_MAP[gi]
                                                      : lvl_s2[gi];
        end
    endgenerate
endmodule
`default_nettype wire

/* File: bench/adc_control_monitor.sv */
// assertion checker bound to the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_control_monitor
    import adc_pkg::*;
#(
    parameter int         NUM_CH     = 10,      // analog inputs
    parameter logic [9:0] PORT_B_MAP = 10'h300  // inputs on port b
) (
    // clock, reset, sleep
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              sleep_mode,
    // register writes
    input wire logic [11:0]       s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    // analog core and pins
    input wire logic              sample_hold,
    input wire logic              converter_power_on,
    input wire logic [3:0]        channel_select,
    input wire logic [1:0]        ref_high_src,
    input wire logic [1:0]        ref_low_src,
    input wire logic [NUM_CH-1:0] pin_analog,
    input wire logic [NUM_CH-1:0] pin_read_value
);
    // {high, low} source nibble per reference code, code 7 leftmost
    localparam logic [31:0] REF_MAP = 32'hc3184b50;
    logic              wr_hs;     // write taken on lane zero
    logic              wr_ctrl0;  // write to control register zero
    logic              wr_ctrl1;  // write to control register one
    logic [7:0]        wd_q;      // written byte, one cycle late
    logic [NUM_CH-1:0] an_exp;    // analog pins for the written code
    assign wr_hs    = s_axi_awvalid && s_axi_awready && s_axi_wstrb[0];
    assign wr_ctrl0 = wr_hs && (s_axi_awaddr == {IDX_CTRL0, 2'h0});
    assign wr_ctrl1 = wr_hs && (s_axi_awaddr == {IDX_CTRL1, 2'h0});
    assign an_exp   = NUM_CH'(10'h3ff >> ((wd_q[3:0] > 4'h5) ? wd_q[3:0] - 4'h5 : 4'h0));
    // hold the written byte so it can be compared after the update
    always_ff @(posedge aclk) begin
        wd_q <= s_axi_wdata[7:0];
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_reset_state: assert property ($rose(aresetn) |->
        sample_hold && !converter_power_on && pin_analog == '1) else $error("bad reset state");
    chk_conv_ends: assert property ($fell(sample_hold) |-> ##[1:1000] sample_hold)
        else $error("conversion never ended");
    chk_start_powered: assert property ($fell(sample_hold) |-> $past(converter_power_on))
        else $error("conversion started unpowered");
    chk_off_idle: assert property (!converter_power_on |=> sample_hold)
        else $error("converting while off");
    chk_port_read: assert property ($stable(pin_analog) |->
        (pin_read_value & pin_analog) == (PORT_B_MAP[NUM_CH-1:0] & pin_analog))
        else $error("analog pin read value wrong");
    chk_ctrl0_fields: assert property (wr_ctrl0 |=>
        channel_select == {wd_q[5:3], wd_q[1]} && converter_power_on == wd_q[0])
        else $error("channel or power field wrong");
    chk_ref_select: assert property (wr_ctrl1 |=>
        {ref_high_src, ref_low_src} == REF_MAP[{wd_q[6:4], 2'h0} +: 4])
        else $error("reference sources wrong");
    chk_pin_config: assert property (wr_ctrl1 |=> pin_analog == an_exp)
        else $error("pin analog map wrong");
    // main scenarios reached
    cov_conv: cover property ($fell(sample_hold));
    cov_sleep_conv: cover property (sleep_mode && !sample_hold);
    cov_all_digital: cover property (wr_ctrl1 ##1 pin_analog == '0);
endmodule
bind adc_control adc_control_monitor #(
    .NUM_CH    (NUM_CH),
    .PORT_B_MAP(PORT_B_MAP)
) adc_control_monitor_inst (
    .aclk, .aresetn, .sleep_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .sample_hold, .converter_power_on, .channel_select,
    .ref_high_src, .ref_low_src, .pin_analog, .pin_read_value
);
`default_nettype wire

/* File: bench/adc_analog_model.sv */
// behavioural analog core: sample-hold, comparator, internal rc oscillator
`timescale 1ns/1ps
`default_nettype none
module adc_analog_model (
    // from the control block
    input  wire logic        sample_hold,
    input  wire logic        converter_power_on,
    input  wire logic [11:0] dac_code,
    input  wire logic        sample_driven_level,
    input  wire logic [3:0]  channel_select,
    input  wire logic [9:0]  pin_level,
    // level on every analog input
    input  wire logic [11:0] analog_in,
    // to the control block
    output logic             comp_in_pin,
    output logic             rc_clock_pin
);
    logic [11:0] held;  // level on the hold capacitor
    logic [11:0] src;   // level behind the input switch
    // a pin driven as output shows its digital level, others their analog level
    assign src = sample_driven_level ? {12{pin_level[channel_select]}} : analog_in;
    // track while idle, hold while converting
    always_latch begin
        if (sample_hold) begin
            held <= src;
        end
    end
    // trial bit kept while held level reaches it
    assign comp_in_pin = converter_power_on ? (held >= dac_code) : rc_clock_pin;
    // free-running oscillator, unrelated in phase to aclk
    initial begin
        rc_clock_pin = 1'b0;
        #3.3;
        forever #18.5 rc_clock_pin = ~rc_clock_pin;
    end
endmodule
`default_nettype wire

/* File: bench/tb_adc_control.sv */
// self-checking testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_control;
    import adc_pkg::*;
    // byte addresses and the applied level
    localparam logic [11:0] A0  = {IDX_CTRL0, 2'h0};
    localparam logic [11:0] A1  = {IDX_CTRL1, 2'h0};
    localparam logic [11:0] ALO = {IDX_RES_LO, 2'h0};
    localparam logic [11:0] AHI = {IDX_RES_HI, 2'h0};
    localparam logic [11:0] AST = {IDX_STATUS, 2'h0};
    localparam logic [11:0] VAL = 12'ha5c;
    logic        aclk, aresetn = 1'b0, sleep_mode = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, bvalid, arready, rvalid, comp, rc_clk, pwr, sh, drv;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0, dac;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0]  rresp, resp_q, refh, refl;
    logic [3:0]  chsel;
    logic [9:0]  pin_dir = 10'h3ff, pin_lvl = 10'h2aa, pin_an, pin_rd, exp_a;
    int          err_count = 0, samples_checked = 0, lo_cnt = 0, last_len = 0, i;
    adc_control adc_control_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sleep_mode(sleep_mode), .rc_clock_pin(rc_clk), .comp_in_pin(comp),
        .converter_power_on(pwr), .sample_hold(sh), .dac_code(dac), .channel_select(chsel),
        .sample_driven_level(drv), .ref_high_src(refh), .ref_low_src(refl),
        .pin_direction(pin_dir), .pin_level(pin_lvl), .pin_analog(pin_an), .pin_read_value(pin_rd)
    );
    adc_analog_model adc_analog_model_inst (
        .sample_hold(sh), .converter_power_on(pwr), .dac_code(dac), .sample_driven_level(drv),
        .channel_select(chsel), .pin_level(pin_lvl), .analog_in(VAL), .comp_in_pin(comp),
        .rc_clock_pin(rc_clk)
    );
    // 200 mhz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // sample_hold low time of the last conversion
    always @(posedge aclk) begin
        if (!sh) begin
            lo_cnt <= lo_cnt + 1;
        end else if (lo_cnt != 0) begin
            last_len <= lo_cnt;
            lo_cnt   <= 0;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    // one register write, address and data offered together
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask
    // one register read
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        v      = rdata;
        resp_q = rresp;
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        rd(a, d);
        chk(d, exp);
    endtask
    // one conversion; m: 0 awake, 1 asleep, 2 asleep then woken; result right justified
    task automatic conv(input logic [7:0] c0, input int m, input logic [11:0] exp);
        wr(AST, 8'h01);
        wr(A0, c0);
        repeat (8) @(posedge aclk);
        sleep_mode <= (m != 0);
        wr(A0, c0 | 8'h04);
        if (m == 2) begin
            repeat (100) @(posedge aclk);
            rc(A0, {24'h0, c0 | 8'h04});
            chk({31'h0, sh}, 0);
            sleep_mode <= 1'b0;
        end
        d = 32'h4;
        while (d[2]) begin
            rd(A0, d);
        end
        sleep_mode <= 1'b0;
        chk(d, {24'h0, c0});
        rc(AST, 1);
        rc(ALO, exp[7:0]);
        rc(AHI, {4'h0, exp[11:8]});
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // cut a hang short
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rc(A0, 0);
        rc(A1, 0);
        rd(12'h100, d);
        chk({30'h0, resp_q}, {30'h0, RESP_SLVERR});
        wr(A0, 8'h05);
        rc(A0, 1);
        $display("test registers done");
        wr(A1, 8'h8f);
        for (i = 0; i < 3; i++) begin
            conv({i[1:0], 6'h01}, 0, VAL);
            chk({31'h0, last_len >= (13 << (2*i+1)) && last_len <= (14 << (2*i+1)) + 4}, 1);
        end
        conv(8'hc1, 1, VAL);
        conv(8'h01, 2, VAL);
        $display("test clock sources done");
        wr(A1, 8'h0f);
        rc(AHI, VAL[11:4]);
        rc(ALO, {VAL[3:0], 4'h0});
        wr(A1, 8'h8f);
        conv(8'h29, 0, 12'hfff);
        conv(8'h23, 0, VAL);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc(A0, 0);
        rc(AHI, VAL[11:4]);
        wr(A1, 8'h8f);
        pin_dir <= 10'h3fe;
        conv(8'h01, 0, 12'h000);
        pin_dir <= 10'h3ff;
        $display("test channels done");
        wr(A0, 8'h81);
        wr(A0, 8'h85);
        repeat (250) @(posedge aclk);
        wr(A0, 8'h81);
        rc(A0, 8'h81);
        rc(AHI, 8'h0a);
        rd(ALO, d);
        chk({28'h0, d[3:0]}, 0);
        $display("test abort done");
        for (i = 0; i < 16; i++) begin
            wr(A1, {1'b1, i[2:0], i[3:0]});
            repeat (2) @(posedge aclk);
            exp_a = (i > 5) ? 10'h3ff >> (i - 5) : 10'h3ff;
            chk({22'h0, pin_an}, {22'h0, exp_a});
            chk({22'h0, pin_rd}, {22'h0, (exp_a & 10'h300) | (~exp_a & pin_lvl)});
        end
        $display("test pins done");
        end_sim();
    end
endmodule
`default_nettype wire
